// ### thermal_alarm_pkg.sv
// constants, field layout and carrier types of the thermal alarm and pin configuration bank
`default_nettype none
package thermal_alarm_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_BOOST_WINDOW = 8'h0D;
  localparam logic [7:0] IDX_ALARM1_SRC   = 8'h0E;
  localparam logic [7:0] IDX_ALARM2_SRC   = 8'h0F;
  localparam logic [7:0] IDX_PIN_FUNC_1   = 8'h10;
  localparam logic [7:0] IDX_PIN_FUNC_2   = 8'h11;
  localparam logic [7:0] IDX_BANK_CTRL    = 8'h20;
  localparam logic [7:0] IDX_ALARM_STATE  = 8'h21;
  localparam logic [7:0] IDX_ALARM1_TIME  = 8'h22;
  localparam logic [7:0] IDX_ALARM2_TIME  = 8'h23;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_BOOST_WINDOW = 8'h00;
  localparam logic [7:0] RST_ALARM_SRC    = 8'h00;
  localparam logic [7:0] RST_PIN_FUNC_1   = 8'h7F;
  localparam logic [7:0] RST_PIN_FUNC_2   = 8'hCE;

  // ==========================================================================
  // field positions
  localparam int BOOST1_BIT      = 0;
  localparam int BOOST2_BIT      = 1;
  localparam int WIN1_LSB        = 2;
  localparam int WIN2_LSB        = 5;
  localparam int WIN_W           = 3;
  localparam int TIMER_EN_BIT    = 0;
  localparam int SRC_LSB         = 1;
  localparam int SRC_W           = 4;
  localparam int SRC_USED_W      = 5;
  localparam int CTRL_SWRST_BIT  = 0;
  localparam int CTRL_LOCK_BIT   = 1;
  localparam int PF1_TWELVE_BIT  = 0;
  localparam int PF1_GPIO_LSB    = 1;
  localparam int PF1_DIODE3_BIT  = 5;
  localparam int PF1_DIODE1_BIT  = 6;
  localparam int PF1_VID_BIT     = 7;
  localparam int PF2_RAIL_LSB    = 0;
  localparam int PF2_FAN_SPEED_INPUT_8_BIT   = 2;
  localparam int PF2_TACH7_BIT   = 3;
  localparam int PF2_LOW19_BIT   = 4;
  localparam int PF2_LOW15_BIT   = 5;
  localparam int PF2_DRIVE4_BIT  = 6;
  localparam int PF2_TACH6_BIT   = 7;

  // ==========================================================================
  // timing: shortest alarm window and the longest window code
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         WINDOW_BASE_NS = 250_000_000;
  localparam int         WINDOW_BASE_CYCLES = WINDOW_BASE_NS / CLK_PERIOD_NS;
  localparam logic [2:0] WIN_CODE_MAX   = 3'h5;

  // ==========================================================================
  // decoded pin functions handed to the pad ring
  typedef struct packed {
    logic [7:0] fan_speed_input_en;   // bit n is input n+1
    logic [3:0] gpio_en;              // general I/O on pins of inputs 1..4
    logic       voltage_id_inputs_en;
    logic       first_twelve_volt_input_en;
    logic       first_remote_diode_en;
    logic       third_remote_diode_en;
    logic       termination_sense_1_en;
    logic       termination_sense_2_en;
    logic       fan_drive_output_4_en;
    logic [1:0] rail_select;
    logic       low_range_third_input;
    logic       low_range_first_input;
  } pin_function_type;

  // over-limit flags: local, remote 1, remote 2, remote 3
  typedef struct packed {
    logic [3:0] alarm1;
    logic [3:0] alarm2;
  } over_limit_type;

endpackage
`default_nettype wire

// ### thermal_alarm_and_pin_config.sv
// AHB-Lite register bank for thermal alarms, alarm timers and pin function select
//
// Functional notes
// - alarm 1 forces fans full unless boost bit 0
// - alarm 2 forces fans full unless boost bit 1
// - bits 4:2 pick alarm 1 window
// - bits 7:5 pick alarm 2 window
// - alarm 1 timer enable, off at reset
// - local over-limit drives alarm pin 1 low
// - remote 1..3 over-limit drive alarm pin 1
// - alarm 2 timer enable, off at reset
// - local over-limit drives alarm pin 2 low
// - remote 1..3 over-limit drive alarm pin 2
// - pin function 1 bit 0: twelve-volt or tach 5
// - bits 1..4 gpio or tach 4..1 unless voltage-id
// - bit 5 third diode or voltage plus term 2
// - bit 6 first diode or voltage plus term 1
// - bit 7 voltage-id inputs override tach pins
// - pin function 2 bits 1:0 select rail
// - bits 2,3,7 voltage or tach 8,7,6
// - bit 4 scale 1.25/0.9 without third diode
// - bit 5 scale 2.5/1.8 without first diode
// - bit 6 3.3 V input or fan drive 4
// - reset values restored by software reset; lock kept until hardware reset
`default_nettype none
module thermal_alarm_and_pin_config #(
  parameter int unsigned WINDOW_BASE_CYCLES = thermal_alarm_pkg::WINDOW_BASE_CYCLES
) (
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic                                     hreadyout,
  output logic                                     hresp,
  output logic [31:0]                              hrdata,
  input  wire thermal_alarm_pkg::over_limit_type   over_limit,
  output logic                                     thermal_alarm_pin_1_o,
  output logic                                     thermal_alarm_pin_1_oe_n,
  output logic                                     thermal_alarm_pin_2_o,
  output logic                                     thermal_alarm_pin_2_oe_n,
  output logic                                     fan_full_drive,
  output thermal_alarm_pkg::pin_function_type      pin_function
);

  // ==========================================================================
  // elaboration check: longest window must fit the 32-bit counters
  if (WINDOW_BASE_CYCLES < 1 || WINDOW_BASE_CYCLES > 32'h07FF_FFFF) begin : g_bad_base
    $error("WINDOW_BASE_CYCLES out of range");
  end

  // ==========================================================================
  // bus slave
  logic [7:0]  boost_window_r;
  logic [7:0]  alarm1_src_r;
  logic [7:0]  alarm2_src_r;
  logic [7:0]  pin_func_1_r;
  logic [7:0]  pin_func_2_r;
  logic        lock_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_idx_r;
  logic        addr_ok_r;
  logic        alarm1_r;
  logic        alarm2_r;
  logic [31:0] alarm_time [2];

  logic        accept;
  logic [7:0]  acc_idx;
  logic        wr_now;
  logic        sw_reset_now;
  logic        cfg_wr_ok;

  assign accept       = hsel && htrans[1] && hready;
  assign acc_idx      = haddr[9:2];
  assign wr_now       = wr_pend_r && addr_ok_r;
  assign sw_reset_now = wr_now && addr_idx_r == thermal_alarm_pkg::IDX_BANK_CTRL
                        && hwdata[thermal_alarm_pkg::CTRL_SWRST_BIT];
  assign cfg_wr_ok    = wr_now && !lock_r && !sw_reset_now;

  function automatic logic [31:0] read_mux(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      thermal_alarm_pkg::IDX_BOOST_WINDOW: v[7:0] = boost_window_r;
      thermal_alarm_pkg::IDX_ALARM1_SRC:   v[7:0] = alarm1_src_r;
      thermal_alarm_pkg::IDX_ALARM2_SRC:   v[7:0] = alarm2_src_r;
      thermal_alarm_pkg::IDX_PIN_FUNC_1:   v[7:0] = pin_func_1_r;
      thermal_alarm_pkg::IDX_PIN_FUNC_2:   v[7:0] = pin_func_2_r;
      thermal_alarm_pkg::IDX_BANK_CTRL:
        v[thermal_alarm_pkg::CTRL_LOCK_BIT] = lock_r;
      thermal_alarm_pkg::IDX_ALARM_STATE:  v[1:0] = {alarm2_r, alarm1_r};
      thermal_alarm_pkg::IDX_ALARM1_TIME:  v = alarm_time[0];
      thermal_alarm_pkg::IDX_ALARM2_TIME:  v = alarm_time[1];
      default:                             v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // reads take one wait state so a read right after a write sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'b0;
      rd_pend_r  <= 1'b0;
      addr_idx_r <= 8'h00;
      addr_ok_r  <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
    end else begin
      if (rd_pend_r) begin
        hrdata    <= addr_ok_r ? read_mux(addr_idx_r) : 32'h0000_0000;
        hreadyout <= 1'b1;
        rd_pend_r <= 1'b0;
      end else if (accept && !hwrite) begin
        hreadyout <= 1'b0;
        rd_pend_r <= 1'b1;
      end
      if (accept) begin
        addr_idx_r <= acc_idx;
        addr_ok_r  <= haddr[31:10] == 22'h00_0000 && haddr[1:0] == 2'h0;
      end
      wr_pend_r <= accept && hwrite;
    end
  end

  // every transfer is answered OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================================
  // lock: once set only a hardware reset clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= 1'b0;
    end else if (wr_now && addr_idx_r == thermal_alarm_pkg::IDX_BANK_CTRL
                 && hwdata[thermal_alarm_pkg::CTRL_LOCK_BIT]) begin
      lock_r <= 1'b1;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boost_window_r <= thermal_alarm_pkg::RST_BOOST_WINDOW;
      alarm1_src_r   <= thermal_alarm_pkg::RST_ALARM_SRC;
      alarm2_src_r   <= thermal_alarm_pkg::RST_ALARM_SRC;
      pin_func_1_r   <= thermal_alarm_pkg::RST_PIN_FUNC_1;
      pin_func_2_r   <= thermal_alarm_pkg::RST_PIN_FUNC_2;
    end else if (sw_reset_now) begin
      boost_window_r <= thermal_alarm_pkg::RST_BOOST_WINDOW;
      alarm1_src_r   <= thermal_alarm_pkg::RST_ALARM_SRC;
      alarm2_src_r   <= thermal_alarm_pkg::RST_ALARM_SRC;
      pin_func_1_r   <= thermal_alarm_pkg::RST_PIN_FUNC_1;
      pin_func_2_r   <= thermal_alarm_pkg::RST_PIN_FUNC_2;
    end else if (cfg_wr_ok) begin
      case (addr_idx_r)
        thermal_alarm_pkg::IDX_BOOST_WINDOW: boost_window_r <= hwdata[7:0];
        thermal_alarm_pkg::IDX_ALARM1_SRC:
          alarm1_src_r <= {3'h0, hwdata[thermal_alarm_pkg::SRC_USED_W-1:0]};
        thermal_alarm_pkg::IDX_ALARM2_SRC:
          alarm2_src_r <= {3'h0, hwdata[thermal_alarm_pkg::SRC_USED_W-1:0]};
        thermal_alarm_pkg::IDX_PIN_FUNC_1:   pin_func_1_r <= hwdata[7:0];
        thermal_alarm_pkg::IDX_PIN_FUNC_2:   pin_func_2_r <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // alarm pins and fan boost
  logic alarm1_nxt;
  logic alarm2_nxt;
  logic boost_nxt;

  // over-limit flags come from the comparators on this clock, so no synchroniser
  assign alarm1_nxt = |(over_limit.alarm1 &
    alarm1_src_r[thermal_alarm_pkg::SRC_LSB +: thermal_alarm_pkg::SRC_W]);
  assign alarm2_nxt = |(over_limit.alarm2 &
    alarm2_src_r[thermal_alarm_pkg::SRC_LSB +: thermal_alarm_pkg::SRC_W]);
  assign boost_nxt  =
    (alarm1_nxt && !boost_window_r[thermal_alarm_pkg::BOOST1_BIT]) ||
    (alarm2_nxt && !boost_window_r[thermal_alarm_pkg::BOOST2_BIT]);

  // open drain: pins only ever pull low, enable is active low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm1_r                 <= 1'b0;
      alarm2_r                 <= 1'b0;
      thermal_alarm_pin_1_o    <= 1'b0;
      thermal_alarm_pin_2_o    <= 1'b0;
      thermal_alarm_pin_1_oe_n <= 1'b1;
      thermal_alarm_pin_2_oe_n <= 1'b1;
      fan_full_drive           <= 1'b0;
    end else begin
      alarm1_r                 <= alarm1_nxt;
      alarm2_r                 <= alarm2_nxt;
      thermal_alarm_pin_1_o    <= 1'b0;
      thermal_alarm_pin_2_o    <= 1'b0;
      thermal_alarm_pin_1_oe_n <= !alarm1_nxt;
      thermal_alarm_pin_2_oe_n <= !alarm2_nxt;
      fan_full_drive           <= boost_nxt;
    end
  end

  // ==========================================================================
  // assertion timers: cycles asserted within each window
  function automatic logic [31:0] window_cycles(input logic [2:0] code);
    logic [2:0] c;
    c = (code > thermal_alarm_pkg::WIN_CODE_MAX) ? thermal_alarm_pkg::WIN_CODE_MAX : code;
    return WINDOW_BASE_CYCLES[31:0] << c;
  endfunction

  logic [1:0] timer_en;
  logic [1:0] alarm_now;
  logic [2:0] win_code [2];

  assign timer_en  = {alarm2_src_r[thermal_alarm_pkg::TIMER_EN_BIT],
                      alarm1_src_r[thermal_alarm_pkg::TIMER_EN_BIT]};
  assign alarm_now = {alarm2_r, alarm1_r};
  assign win_code[0] = boost_window_r[thermal_alarm_pkg::WIN1_LSB +: thermal_alarm_pkg::WIN_W];
  assign win_code[1] = boost_window_r[thermal_alarm_pkg::WIN2_LSB +: thermal_alarm_pkg::WIN_W];

  logic [1:0] win_end;

  for (genvar g = 0; g < 2; g++) begin : g_timer
    logic [31:0] win_cnt_r;
    logic [31:0] asrt_cnt_r;
    logic [31:0] time_r;
    logic [31:0] asrt_inc;

    assign asrt_inc      = asrt_cnt_r + {31'h0000_0000, alarm_now[g]};
    assign win_end[g]    = timer_en[g] && win_cnt_r >= window_cycles(win_code[g]) - 32'h1;
    assign alarm_time[g] = time_r;

    // a shortened window takes effect at once; a disabled timer clears its result
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        win_cnt_r  <= 32'h0000_0000;
        asrt_cnt_r <= 32'h0000_0000;
        time_r     <= 32'h0000_0000;
      end else if (!timer_en[g]) begin
        win_cnt_r  <= 32'h0000_0000;
        asrt_cnt_r <= 32'h0000_0000;
        time_r     <= 32'h0000_0000;
      end else if (win_end[g]) begin
        win_cnt_r  <= 32'h0000_0000;
        asrt_cnt_r <= 32'h0000_0000;
        time_r     <= asrt_inc;
      end else begin
        win_cnt_r  <= win_cnt_r + 32'h1;
        asrt_cnt_r <= asrt_inc;
      end
    end
  end

  // ==========================================================================
  // pin function decode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_function <= '0;
    end else begin
      pin_function.first_twelve_volt_input_en <=
        !pin_func_1_r[thermal_alarm_pkg::PF1_TWELVE_BIT];
      pin_function.fan_speed_input_en[4] <= pin_func_1_r[thermal_alarm_pkg::PF1_TWELVE_BIT];
      pin_function.voltage_id_inputs_en <= pin_func_1_r[thermal_alarm_pkg::PF1_VID_BIT];
      for (int i = 0; i < 4; i++) begin
        pin_function.fan_speed_input_en[3 - i] <= !pin_func_1_r[thermal_alarm_pkg::PF1_VID_BIT]
          && pin_func_1_r[thermal_alarm_pkg::PF1_GPIO_LSB + i];
        pin_function.gpio_en[3 - i] <= !pin_func_1_r[thermal_alarm_pkg::PF1_VID_BIT]
          && !pin_func_1_r[thermal_alarm_pkg::PF1_GPIO_LSB + i];
      end
      pin_function.third_remote_diode_en  <= pin_func_1_r[thermal_alarm_pkg::PF1_DIODE3_BIT];
      pin_function.termination_sense_2_en <= !pin_func_1_r[thermal_alarm_pkg::PF1_DIODE3_BIT];
      pin_function.first_remote_diode_en  <= pin_func_1_r[thermal_alarm_pkg::PF1_DIODE1_BIT];
      pin_function.termination_sense_1_en <= !pin_func_1_r[thermal_alarm_pkg::PF1_DIODE1_BIT];
      pin_function.rail_select <= pin_func_2_r[thermal_alarm_pkg::PF2_RAIL_LSB +: 2];
      pin_function.fan_speed_input_en[7] <= pin_func_2_r[thermal_alarm_pkg::PF2_FAN_SPEED_INPUT_8_BIT];
      pin_function.fan_speed_input_en[6] <= pin_func_2_r[thermal_alarm_pkg::PF2_TACH7_BIT];
      pin_function.fan_speed_input_en[5] <= pin_func_2_r[thermal_alarm_pkg::PF2_TACH6_BIT];
      pin_function.low_range_third_input <= pin_func_2_r[thermal_alarm_pkg::PF2_LOW19_BIT]
        && !pin_func_1_r[thermal_alarm_pkg::PF1_DIODE3_BIT];
      pin_function.low_range_first_input <= pin_func_2_r[thermal_alarm_pkg::PF2_LOW15_BIT]
        && !pin_func_1_r[thermal_alarm_pkg::PF1_DIODE1_BIT];
      pin_function.fan_drive_output_4_en <= pin_func_2_r[thermal_alarm_pkg::PF2_DRIVE4_BIT];
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  alarm1_drive_a: assert property (
    (over_limit.alarm1[0] && alarm1_src_r[1]) |=> !thermal_alarm_pin_1_oe_n)
    else $error("alarm pin 1 not driven for local over-limit");
  alarm1_remote_a: assert property (
    (|(over_limit.alarm1[3:1] & alarm1_src_r[4:2])) |=> !thermal_alarm_pin_1_oe_n)
    else $error("alarm pin 1 not driven for remote over-limit");
  alarm2_drive_a: assert property (
    (over_limit.alarm2[0] && alarm2_src_r[1]) |=> !thermal_alarm_pin_2_oe_n)
    else $error("alarm pin 2 not driven for local over-limit");
  alarm2_remote_a: assert property (
    (|(over_limit.alarm2[3:1] & alarm2_src_r[4:2])) |=> !thermal_alarm_pin_2_oe_n)
    else $error("alarm pin 2 not driven for remote over-limit");
  alarm_release_a: assert property (
    !(|(over_limit.alarm1 & alarm1_src_r[4:1])) |=> thermal_alarm_pin_1_oe_n)
    else $error("alarm pin 1 held without source");
  src_reserved_a: assert property (
    alarm1_src_r[7:5] == 3'h0 && alarm2_src_r[7:5] == 3'h0)
    else $error("reserved source bits set");
  fan_boost1_a: assert property (
    (!thermal_alarm_pin_1_oe_n && !$past(boost_window_r[0])) |-> fan_full_drive)
    else $error("fans not forced by alarm 1");
  fan_boost2_a: assert property (
    (fan_full_drive && thermal_alarm_pin_1_oe_n) |-> !thermal_alarm_pin_2_oe_n && !$past(boost_window_r[1]))
    else $error("fans forced without alarm 2 boost");
  lock_hold_a: assert property (
    (lock_r && !sw_reset_now) |=> $stable(pin_func_1_r) && $stable(alarm1_src_r))
    else $error("locked register changed");
  sw_reset_a: assert property (
    sw_reset_now |=> pin_func_2_r == thermal_alarm_pkg::RST_PIN_FUNC_2
                     && pin_func_1_r == thermal_alarm_pkg::RST_PIN_FUNC_1)
    else $error("software reset did not restore registers");
  timer_off_a: assert property (
    !timer_en[0] |=> alarm_time[0] == 32'h0000_0000)
    else $error("disabled timer holds a result");
  vid_override_a: assert property (
    $past(pin_func_1_r[7]) |-> pin_function.fan_speed_input_en[3:0] == 4'h0)
    else $error("tach inputs active with voltage-id");
  read_wait_a: assert property (
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  alarm2_release_a: assert property (
    !(|(over_limit.alarm2 & alarm2_src_r[4:1])) |=> thermal_alarm_pin_2_oe_n)
    else $error("alarm pin 2 held without source");
  timer2_off_a: assert property (
    !timer_en[1] |=> alarm_time[1] == 32'h0000_0000)
    else $error("disabled timer 2 holds a result");
  open_drain_a: assert property (
    !thermal_alarm_pin_1_o && !thermal_alarm_pin_2_o)
    else $error("alarm pin driven high");
  okay_resp_a: assert property (!hresp)
    else $error("bus response not OKAY");
  twelve_volt_a: assert property (
    !(pin_function.first_twelve_volt_input_en && pin_function.fan_speed_input_en[4]))
    else $error("twelve-volt input and tach 5 both on");
  gpio_tach_a: assert property (
    (pin_function.gpio_en & pin_function.fan_speed_input_en[3:0]) == 4'h0)
    else $error("pin is both general I/O and tach input");
  diode3_term_a: assert property (
    !(pin_function.third_remote_diode_en && pin_function.termination_sense_2_en))
    else $error("third diode and termination sense 2 both on");
  diode1_term_a: assert property (
    !(pin_function.first_remote_diode_en && pin_function.termination_sense_1_en))
    else $error("first diode and termination sense 1 both on");
  low_range3_a: assert property (
    pin_function.low_range_third_input |-> !pin_function.third_remote_diode_en)
    else $error("third input scaled while diode selected");
  low_range1_a: assert property (
    pin_function.low_range_first_input |-> !pin_function.first_remote_diode_en)
    else $error("first input scaled while diode selected");

  alarm_seen_c:  cover property (!thermal_alarm_pin_1_oe_n && !thermal_alarm_pin_2_oe_n);
  locked_wr_c:   cover property (lock_r && cfg_wr_ok == 1'b0 && wr_now);
  window_end_c:  cover property (win_end[0] && alarm_time[0] == 32'h0000_0000 && alarm1_r);
  relock_rst_c:  cover property (sw_reset_now && lock_r);
  window2_end_c: cover property (win_end[1] && alarm2_r);

endmodule // thermal_alarm_and_pin_config
`default_nettype wire

// ### alarm_sensor_model.sv
// sensor comparators and board pull-ups around the thermal alarm bank
`default_nettype none
module alarm_sensor_model (
  input  wire logic                         hclk,
  input  wire logic [7:0]                   want,
  output thermal_alarm_pkg::over_limit_type over_limit,
  input  wire logic                         pin1_o,
  input  wire logic                         pin1_oe_n,
  input  wire logic                         pin2_o,
  input  wire logic                         pin2_oe_n,
  output logic                              pin1_level,
  output logic                              pin2_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // flags move only on the clock, as real limit logic would
  always_ff @(posedge hclk) over_limit <= thermal_alarm_pkg::over_limit_type'(want);
  // released pins are pulled high, never left at the last driven value
  assign pin1_level = pin1_oe_n ? 1'b1 : pin1_o;
  assign pin2_level = pin2_oe_n ? 1'b1 : pin2_o;
endmodule // alarm_sensor_model
`default_nettype wire

// ### thermal_alarm_and_pin_config_bench.sv
// self-checking bench for the thermal alarm and pin configuration bank
`default_nettype none
module thermal_alarm_and_pin_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ffd;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  want;
  logic        p1_o, p1_oe_n, p2_o, p2_oe_n, lvl1, lvl2;
  int          fails, checks_done;
  thermal_alarm_pkg::over_limit_type   over_limit;
  thermal_alarm_pkg::pin_function_type pin_function;
  logic [7:0] pa[5] = '{8'h00, 8'hFF, 8'h80, 8'h55, 8'h2A};
  logic [7:0] pb[5] = '{8'h00, 8'hFF, 8'h31, 8'h0E, 8'hC0};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'hCE};

  thermal_alarm_and_pin_config #(.WINDOW_BASE_CYCLES(BASE)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .over_limit(over_limit),
    .thermal_alarm_pin_1_o(p1_o), .thermal_alarm_pin_1_oe_n(p1_oe_n),
    .thermal_alarm_pin_2_o(p2_o), .thermal_alarm_pin_2_oe_n(p2_oe_n),
    .fan_full_drive(ffd), .pin_function(pin_function));
  alarm_sensor_model far_side (
    .hclk(hclk), .want(want), .over_limit(over_limit), .pin1_o(p1_o),
    .pin1_oe_n(p1_oe_n), .pin2_o(p2_o), .pin2_oe_n(p2_oe_n),
    .pin1_level(lvl1), .pin2_level(lvl2));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction
  function automatic thermal_alarm_pkg::pin_function_type exp_pf(input logic [7:0] a,
                                                                 input logic [7:0] b);
    thermal_alarm_pkg::pin_function_type e;
    logic [3:0] t;
    t = {a[1], a[2], a[3], a[4]};
    e.fan_speed_input_en = {b[2], b[3], b[7], a[0], t & {4{!a[7]}}};
    e.gpio_en = ~t & {4{!a[7]}};
    e.voltage_id_inputs_en = a[7];
    e.first_twelve_volt_input_en = !a[0];
    e.first_remote_diode_en = a[6];
    e.third_remote_diode_en = a[5];
    e.termination_sense_1_en = !a[6];
    e.termination_sense_2_en = !a[5];
    e.fan_drive_output_4_en = b[6];
    e.rail_select = b[1:0];
    e.low_range_third_input = b[4] & !a[5];
    e.low_range_first_input = b[5] & !a[6];
    return e;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // no cycle limit: only the watchdog ends a wait that never finishes
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  // one single word transfer; read data kept in rd
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge hclk);
  endtask
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and tests
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #300000;
    fails++;
    complete_run();
  end
  initial begin
    int sh;
    {hsel, hwrite, htrans, haddr, hwdata, want, hresetn} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // the release edge still sees reset; decode shows on the next edge
    nap(2);
    check(pin_function, exp_pf(8'h7F, 8'hCE));
    for (int i = 0; i < 5; i++) begin
      xfer(0, ad(8'h0D + i[7:0]), 0);
      check(rd, {24'h0, rv[i]});
    end
    check(hresp, 0);
    for (int i = 0; i < 5; i++) begin
      xfer(1, ad(thermal_alarm_pkg::IDX_PIN_FUNC_1), {24'h0, pa[i]});
      xfer(1, ad(thermal_alarm_pkg::IDX_PIN_FUNC_2), {24'h0, pb[i]});
      xfer(0, ad(thermal_alarm_pkg::IDX_PIN_FUNC_2), 0);
      check(rd, {24'h0, pb[i]});
      nap(1);
      check(pin_function, exp_pf(pa[i], pb[i]));
    end
    xfer(1, ad(thermal_alarm_pkg::IDX_ALARM2_SRC), 32'hFF);
    xfer(0, ad(thermal_alarm_pkg::IDX_ALARM2_SRC), 0);
    check(rd, 32'h1F);
    // each source alone, source k with boost setting k; other sources of that pin held over limit
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 4; k++) begin
        sh = a ? k : k + 4;
        xfer(1, ad(thermal_alarm_pkg::IDX_BOOST_WINDOW), k);
        xfer(1, ad(thermal_alarm_pkg::IDX_ALARM1_SRC), a ? 0 : 32'h2 << k);
        xfer(1, ad(thermal_alarm_pkg::IDX_ALARM2_SRC), a ? 32'h2 << k : 0);
        @(posedge hclk) want <= (a ? 8'h0F : 8'hF0) & ~(8'h01 << sh);
        nap(3);
        check({a ? p2_oe_n : p1_oe_n, a ? lvl2 : lvl1, ffd}, 3'h6);
        @(posedge hclk) want <= 8'h01 << sh;
        nap(3);
        check({a ? p2_oe_n : p1_oe_n, a ? lvl2 : lvl1, ffd}, {2'h0, !k[a]});
        @(posedge hclk) want <= 8'h00;
      end
    end
    // window codes 0 and 6: the latter must clamp to the longest window
    xfer(1, ad(thermal_alarm_pkg::IDX_BOOST_WINDOW), 32'hC0);
    xfer(1, ad(thermal_alarm_pkg::IDX_ALARM1_SRC), 32'h03);
    xfer(1, ad(thermal_alarm_pkg::IDX_ALARM2_SRC), 32'h03);
    @(posedge hclk) want <= 8'h11;
    nap(800);
    xfer(0, ad(thermal_alarm_pkg::IDX_ALARM1_TIME), 0);
    check(rd, BASE);
    xfer(0, ad(thermal_alarm_pkg::IDX_ALARM2_TIME), 0);
    check(rd, BASE * 32);
    xfer(0, ad(thermal_alarm_pkg::IDX_ALARM_STATE), 0);
    check(rd, 32'h3);
    xfer(1, ad(thermal_alarm_pkg::IDX_ALARM1_SRC), 32'h02);
    xfer(0, ad(thermal_alarm_pkg::IDX_ALARM1_TIME), 0);
    check(rd, 0);
    xfer(1, ad(thermal_alarm_pkg::IDX_BANK_CTRL), 32'h2);
    xfer(1, ad(thermal_alarm_pkg::IDX_PIN_FUNC_2), 0);
    xfer(0, ad(thermal_alarm_pkg::IDX_PIN_FUNC_2), 0);
    check(rd, 32'hC0);
    xfer(1, ad(thermal_alarm_pkg::IDX_BANK_CTRL), 32'h1);
    for (int i = 0; i < 5; i++) begin
      xfer(0, ad(8'h0D + i[7:0]), 0);
      check(rd, {24'h0, rv[i]});
    end
    check(pin_function, exp_pf(8'h7F, 8'hCE));
    xfer(1, 32'h400, 32'h55);
    xfer(0, 32'h400, 0);
    check(rd, 0);
    complete_run();
  end
endmodule // thermal_alarm_and_pin_config_bench
`default_nettype wire
